// ### rfa_cfg.svh
`ifndef RFA_CFG_SVH
`define RFA_CFG_SVH

`define RFA_DATA_W 32
`define RFA_RW_LSB 0
`define RFA_RW_MSB 3
`define RFA_RWH_LSB 4
`define RFA_RWH_MSB 7
`define RFA_RO_LSB 8
`define RFA_RO_MSB 11
`define RFA_WO_LSB 12
`define RFA_WO_MSB 15
`define RFA_STAT_LSB 16
`define RFA_STAT_MSB 19
`define RFA_STICKY_LSB 20
`define RFA_STICKY_MSB 21
`define RFA_FETCH_BIT 22
`define RFA_RSVD_LSB 23
`define RFA_RSVD_MSB 31

`define RFA_FIELD_W 4
`define RFA_STICKY_W 2
`define RFA_RSVD_W 9

`define RFA_RW_RST 4'h0
`define RFA_RWH_RST 4'h0
`define RFA_RO_DEFAULT 4'hA
`define RFA_WO_RST 4'h0
`define RFA_WO_READ 4'h0
`define RFA_STAT_RST 4'h0
`define RFA_STICKY_RST 2'h0
`define RFA_FETCH_RST 1'h0
`define RFA_FETCH_DATA_READ 1'h0
`define RFA_RSVD_READ 9'h000

`define RFA_SYNC_DEPTH 3

`endif

// ### rfa_pkg.sv
`include "rfa_cfg.svh"

package rfa_pkg;

	typedef logic [`RFA_DATA_W-1:0] rfa_word_type;
	typedef logic [`RFA_FIELD_W-1:0] rfa_field_type;

	typedef struct packed {
		rfa_field_type rw;
		rfa_field_type rwh;
		rfa_field_type wo;
		rfa_field_type status;
		logic [`RFA_STICKY_W-1:0] sticky;
		logic fetch_bit;
		rfa_word_type rdata;
		logic rvalid;
	} rfa_regs_state_type;

	typedef struct packed {
		logic [`RFA_SYNC_DEPTH-1:0] rel;
		logic [`RFA_SYNC_DEPTH-1:0] req_a;
		logic [`RFA_SYNC_DEPTH-1:0] req_b;
		logic req_a_stable;
		logic req_b_stable;
		logic clocked_reset;
	} rfa_sync_state_type;

endpackage : rfa_pkg

// ### rfa_reset_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "rfa_cfg.svh"

module rfa_reset_ctrl (
	input wire logic REF_CLK,
	input wire logic RST_B,
	input wire logic EXTERNAL_REQUEST_INPUT_A,
	input wire logic EXTERNAL_REQUEST_INPUT_B,
	input wire logic WATCHDOG_TRIGGER,
	input wire logic PARITY_TRIGGER,
	input wire logic SW_RESET_TRIGGER,
	output logic sync_rst_b,
	output logic clocked_reset
);
	import rfa_pkg::*;

	rfa_sync_state_type st_reg;
	rfa_sync_state_type st_next;

	////////////////////////////////////////////////////////////////////////////

	always_comb begin
		st_next = st_reg;
		// The release ripples through the chain, so leaving reset waits for the clock.
		st_next.rel = {st_reg.rel[`RFA_SYNC_DEPTH-2:0], 1'h1};
		st_next.req_a = {st_reg.req_a[`RFA_SYNC_DEPTH-2:0], EXTERNAL_REQUEST_INPUT_A};
		st_next.req_b = {st_reg.req_b[`RFA_SYNC_DEPTH-2:0], EXTERNAL_REQUEST_INPUT_B};
		if (st_reg.req_a[`RFA_SYNC_DEPTH-2] == st_reg.req_a[`RFA_SYNC_DEPTH-1]) begin
			st_next.req_a_stable = st_reg.req_a[`RFA_SYNC_DEPTH-1];
		end
		if (st_reg.req_b[`RFA_SYNC_DEPTH-2] == st_reg.req_b[`RFA_SYNC_DEPTH-1]) begin
			st_next.req_b_stable = st_reg.req_b[`RFA_SYNC_DEPTH-1];
		end
		// These sources only act on a clock edge, unlike the power-on pin.
		st_next.clocked_reset = st_reg.req_a_stable | st_reg.req_b_stable | WATCHDOG_TRIGGER
			| PARITY_TRIGGER | SW_RESET_TRIGGER;
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sync_rst_b = st_reg.rel[`RFA_SYNC_DEPTH-1];
	assign clocked_reset = st_reg.clocked_reset;

	////////////////////////////////////////////////////////////////////////////

	property p_release_delay;
		@(posedge REF_CLK) disable iff (!RST_B)
		$rose(sync_rst_b) |-> $past(RST_B, 2) && !$past(sync_rst_b, 1);
	endproperty
	a_release_delay: assert property (p_release_delay) else $error("Reset released early.");

	property p_trigger_reset;
		@(posedge REF_CLK) disable iff (!RST_B)
		(WATCHDOG_TRIGGER || PARITY_TRIGGER || SW_RESET_TRIGGER) |=> clocked_reset;
	endproperty
	a_trigger_reset: assert property (p_trigger_reset) else $error("Clocked reset missing.");

endmodule : rfa_reset_ctrl

`default_nettype wire

// ### rfa_regs.sv
// Behaviour
// - Reserved field bits always read as zero, whatever was written.
// - Read/write field holds and returns the last software write.
// - Hardware-updatable field acts as read/write, and hardware may also load it.
// - Read-only field returns its value; software writes leave it unchanged.
// - Write-only field takes writes but reads back a fixed default.
// - Status field changes only by hardware; software writes are ignored.
// - Sticky bits, once moved off reset value by software, return only by reset, except the upper bit, which a hardware load may also set or clear.
// - Fetch-readable bit shows its value only to instruction fetches.
// - Power-on reset asserts asynchronously; its release is synchronised to the clock.
// - Request, watchdog, parity and software resets need the clock to assert.
`timescale 1ns/1ps
`default_nettype none
`include "rfa_cfg.svh"

module rfa_regs #(
	parameter logic [`RFA_FIELD_W-1:0] RO_VALUE = `RFA_RO_DEFAULT
) (
	input wire logic REF_CLK,
	input wire logic RST_B,
	input wire logic EXTERNAL_REQUEST_INPUT_A,
	input wire logic EXTERNAL_REQUEST_INPUT_B,
	input wire logic WATCHDOG_TRIGGER,
	input wire logic PARITY_TRIGGER,
	input wire logic SW_RESET_TRIGGER,
	input wire logic SW_WR,
	input wire rfa_pkg::rfa_word_type SW_WDATA,
	input wire logic SW_RD,
	input wire logic SW_FETCH,
	output rfa_pkg::rfa_word_type SW_RDATA,
	output logic SW_RVALID,
	input wire logic HW_RWH_LOAD,
	input wire rfa_pkg::rfa_field_type HW_RWH_VALUE,
	input wire logic HW_STATUS_LOAD,
	input wire rfa_pkg::rfa_field_type HW_STATUS_VALUE,
	input wire logic HW_STICKY_LOAD,
	input wire logic HW_STICKY_VALUE,
	output rfa_pkg::rfa_field_type RW_FIELD,
	output rfa_pkg::rfa_field_type RWH_FIELD,
	output rfa_pkg::rfa_field_type WO_FIELD,
	output rfa_pkg::rfa_field_type HARDWARE_STATUS_FIELD,
	output logic [`RFA_STICKY_W-1:0] STICKY_BITS,
	output logic FETCH_BIT,
	output logic INT_RST_B,
	output logic CLOCKED_RESET
);
	import rfa_pkg::*;

	localparam rfa_regs_state_type RESET_STATE = '{
		rw: `RFA_RW_RST,
		rwh: `RFA_RWH_RST,
		wo: `RFA_WO_RST,
		status: `RFA_STAT_RST,
		sticky: `RFA_STICKY_RST,
		fetch_bit: `RFA_FETCH_RST,
		rdata: '0,
		rvalid: 1'h0
	};
	localparam logic [`RFA_STICKY_W-1:0] STICKY_RST = `RFA_STICKY_RST;

	rfa_regs_state_type st_reg;
	rfa_regs_state_type st_next;
	logic sync_rst_b;
	logic clocked_reset;

	////////////////////////////////////////////////////////////////////////////

	rfa_reset_ctrl u_reset_ctrl (
		.REF_CLK(REF_CLK),
		.RST_B(RST_B),
		.EXTERNAL_REQUEST_INPUT_A(EXTERNAL_REQUEST_INPUT_A),
		.EXTERNAL_REQUEST_INPUT_B(EXTERNAL_REQUEST_INPUT_B),
		.WATCHDOG_TRIGGER(WATCHDOG_TRIGGER),
		.PARITY_TRIGGER(PARITY_TRIGGER),
		.SW_RESET_TRIGGER(SW_RESET_TRIGGER),
		.sync_rst_b(sync_rst_b),
		.clocked_reset(clocked_reset)
	);

	////////////////////////////////////////////////////////////////////////////

	function automatic rfa_word_type read_word(input rfa_regs_state_type s, input logic fetch);
		rfa_word_type w;
		w = '0;
		w[`RFA_RW_MSB:`RFA_RW_LSB] = s.rw;
		w[`RFA_RWH_MSB:`RFA_RWH_LSB] = s.rwh;
		w[`RFA_RO_MSB:`RFA_RO_LSB] = RO_VALUE;
		w[`RFA_WO_MSB:`RFA_WO_LSB] = `RFA_WO_READ;
		w[`RFA_STAT_MSB:`RFA_STAT_LSB] = s.status;
		w[`RFA_STICKY_MSB:`RFA_STICKY_LSB] = s.sticky;
		w[`RFA_FETCH_BIT] = fetch ? s.fetch_bit : `RFA_FETCH_DATA_READ;
		w[`RFA_RSVD_MSB:`RFA_RSVD_LSB] = `RFA_RSVD_READ;
		return w;
	endfunction : read_word

	always_comb begin
		st_next = st_reg;
		st_next.rvalid = SW_RD;
		if (SW_RD) begin
			st_next.rdata = read_word(st_reg, SW_FETCH);
		end
		// Reserved bits of the write data are simply dropped, so a careless write costs nothing.
		if (SW_WR) begin
			st_next.rw = SW_WDATA[`RFA_RW_MSB:`RFA_RW_LSB];
			st_next.rwh = SW_WDATA[`RFA_RWH_MSB:`RFA_RWH_LSB];
			st_next.wo = SW_WDATA[`RFA_WO_MSB:`RFA_WO_LSB];
			st_next.fetch_bit = SW_WDATA[`RFA_FETCH_BIT];
			for (int i = 0; i < `RFA_STICKY_W; i++) begin
				if (st_reg.sticky[i] == STICKY_RST[i]) begin
					st_next.sticky[i] = SW_WDATA[`RFA_STICKY_LSB + i];
				end
			end
		end
		// Hardware loads come after the software write so that they take precedence.
		if (HW_RWH_LOAD) begin
			st_next.rwh = HW_RWH_VALUE;
		end
		if (HW_STICKY_LOAD) begin
			st_next.sticky[1] = HW_STICKY_VALUE;
		end
		if (HW_STATUS_LOAD) begin
			st_next.status = HW_STATUS_VALUE;
		end
		if (clocked_reset) begin
			st_next = RESET_STATE;
		end
	end

	always_ff @(posedge REF_CLK or negedge sync_rst_b) begin
		if (!sync_rst_b) begin
			st_reg <= RESET_STATE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign SW_RDATA = st_reg.rdata;
	assign SW_RVALID = st_reg.rvalid;
	assign RW_FIELD = st_reg.rw;
	assign RWH_FIELD = st_reg.rwh;
	assign WO_FIELD = st_reg.wo;
	assign HARDWARE_STATUS_FIELD = st_reg.status;
	assign STICKY_BITS = st_reg.sticky;
	assign FETCH_BIT = st_reg.fetch_bit;
	assign INT_RST_B = sync_rst_b;
	assign CLOCKED_RESET = clocked_reset;

	////////////////////////////////////////////////////////////////////////////

	property p_reserved_zero;
		@(posedge REF_CLK) disable iff (!sync_rst_b)
		SW_RVALID |-> SW_RDATA[`RFA_RSVD_MSB:`RFA_RSVD_LSB] == '0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits nonzero.");

	property p_rw_hold;
		@(posedge REF_CLK) disable iff (!sync_rst_b)
		(SW_WR && !clocked_reset) ##1 (!SW_WR && !clocked_reset)
			|=> RW_FIELD == $past(SW_WDATA[`RFA_RW_MSB:`RFA_RW_LSB], 2);
	endproperty
	a_rw_hold: assert property (p_rw_hold) else $error("Read/write field lost value.");

	property p_rwh_sw;
		@(posedge REF_CLK) disable iff (!sync_rst_b)
		(SW_WR && !HW_RWH_LOAD && !clocked_reset)
			|=> RWH_FIELD == $past(SW_WDATA[`RFA_RWH_MSB:`RFA_RWH_LSB]);
	endproperty
	a_rwh_sw: assert property (p_rwh_sw) else $error("Updatable field ignored write.");

	property p_rwh_prio;
		@(posedge REF_CLK) disable iff (!sync_rst_b)
		(HW_RWH_LOAD && !clocked_reset) |=> RWH_FIELD == $past(HW_RWH_VALUE);
	endproperty
	a_rwh_prio: assert property (p_rwh_prio) else $error("Hardware load lost.");

	property p_ro_read;
		@(posedge REF_CLK) disable iff (!sync_rst_b)
		(SW_RD && !clocked_reset) |=> SW_RVALID && SW_RDATA[`RFA_RO_MSB:`RFA_RO_LSB] == RO_VALUE;
	endproperty
	a_ro_read: assert property (p_ro_read) else $error("Read-only field wrong.");

	property p_wo_read;
		@(posedge REF_CLK) disable iff (!sync_rst_b)
		SW_RD |=> SW_RDATA[`RFA_WO_MSB:`RFA_WO_LSB] == `RFA_WO_READ;
	endproperty
	a_wo_read: assert property (p_wo_read) else $error("Write-only field read back.");

	property p_status_sw;
		@(posedge REF_CLK) disable iff (!sync_rst_b)
		(!HW_STATUS_LOAD && !clocked_reset) |=> $stable(HARDWARE_STATUS_FIELD);
	endproperty
	a_status_sw: assert property (p_status_sw) else $error("Status changed by software.");

	property p_sticky_hold;
		@(posedge REF_CLK) disable iff (!sync_rst_b)
		(STICKY_BITS[0] != STICKY_RST[0] && !clocked_reset) |=> STICKY_BITS[0] == $past(STICKY_BITS[0]);
	endproperty
	a_sticky_hold: assert property (p_sticky_hold) else $error("Sticky bit returned.");

	property p_fetch_read;
		@(posedge REF_CLK) disable iff (!sync_rst_b)
		(SW_RD && !clocked_reset) |=> SW_RDATA[`RFA_FETCH_BIT] ==
			($past(SW_FETCH) ? $past(FETCH_BIT) : `RFA_FETCH_DATA_READ);
	endproperty
	a_fetch_read: assert property (p_fetch_read) else $error("Fetch bit read wrong.");

	// A clocked reset in the same cycle clears everything, so those cycles are left out below.
	property p_rw_sw;
		@(posedge REF_CLK) disable iff (!sync_rst_b)
		(SW_WR && !clocked_reset) |=> RW_FIELD == $past(SW_WDATA[`RFA_RW_MSB:`RFA_RW_LSB]);
	endproperty
	a_rw_sw: assert property (p_rw_sw) else $error("Read/write field missed write.");

	property p_rw_stable;
		@(posedge REF_CLK) disable iff (!sync_rst_b)
		(!SW_WR && !clocked_reset) |=> $stable(RW_FIELD);
	endproperty
	a_rw_stable: assert property (p_rw_stable) else $error("Read/write field drifted.");

	property p_rwh_stable;
		@(posedge REF_CLK) disable iff (!sync_rst_b)
		(!SW_WR && !HW_RWH_LOAD && !clocked_reset) |=> $stable(RWH_FIELD);
	endproperty
	a_rwh_stable: assert property (p_rwh_stable) else $error("Updatable field drifted.");

	property p_wo_store;
		@(posedge REF_CLK) disable iff (!sync_rst_b)
		(SW_WR && !clocked_reset) |=> WO_FIELD == $past(SW_WDATA[`RFA_WO_MSB:`RFA_WO_LSB]);
	endproperty
	a_wo_store: assert property (p_wo_store) else $error("Write-only field missed write.");

	property p_status_load;
		@(posedge REF_CLK) disable iff (!sync_rst_b)
		(HW_STATUS_LOAD && !clocked_reset) |=> HARDWARE_STATUS_FIELD == $past(HW_STATUS_VALUE);
	endproperty
	a_status_load: assert property (p_status_load) else $error("Status load lost.");

	property p_sticky_take;
		@(posedge REF_CLK) disable iff (!sync_rst_b)
		(SW_WR && STICKY_BITS[0] == STICKY_RST[0] && !clocked_reset)
			|=> STICKY_BITS[0] == $past(SW_WDATA[`RFA_STICKY_LSB]);
	endproperty
	a_sticky_take: assert property (p_sticky_take) else $error("Sticky bit missed write.");

	// Only hardware may move the upper sticky bit once software has moved it.
	property p_sticky_lock;
		@(posedge REF_CLK) disable iff (!sync_rst_b)
		(STICKY_BITS[1] != STICKY_RST[1] && !HW_STICKY_LOAD && !clocked_reset)
			|=> $stable(STICKY_BITS[1]);
	endproperty
	a_sticky_lock: assert property (p_sticky_lock) else $error("Upper sticky bit returned.");

	property p_sticky_hw;
		@(posedge REF_CLK) disable iff (!sync_rst_b)
		(HW_STICKY_LOAD && !clocked_reset) |=> STICKY_BITS[1] == $past(HW_STICKY_VALUE);
	endproperty
	a_sticky_hw: assert property (p_sticky_hw) else $error("Sticky load lost.");

	property p_fetch_store;
		@(posedge REF_CLK) disable iff (!sync_rst_b)
		(SW_WR && !clocked_reset) |=> FETCH_BIT == $past(SW_WDATA[`RFA_FETCH_BIT]);
	endproperty
	a_fetch_store: assert property (p_fetch_store) else $error("Fetch bit missed write.");

	property p_rd_rw;
		@(posedge REF_CLK) disable iff (!sync_rst_b)
		(SW_RD && !clocked_reset) |=> SW_RDATA[`RFA_RW_MSB:`RFA_RW_LSB] == $past(RW_FIELD);
	endproperty
	a_rd_rw: assert property (p_rd_rw) else $error("Read/write field read wrong.");

	property p_rd_rwh;
		@(posedge REF_CLK) disable iff (!sync_rst_b)
		(SW_RD && !clocked_reset) |=> SW_RDATA[`RFA_RWH_MSB:`RFA_RWH_LSB] == $past(RWH_FIELD);
	endproperty
	a_rd_rwh: assert property (p_rd_rwh) else $error("Updatable field read wrong.");

	property p_rd_status;
		@(posedge REF_CLK) disable iff (!sync_rst_b)
		(SW_RD && !clocked_reset)
			|=> SW_RDATA[`RFA_STAT_MSB:`RFA_STAT_LSB] == $past(HARDWARE_STATUS_FIELD);
	endproperty
	a_rd_status: assert property (p_rd_status) else $error("Status field read wrong.");

	property p_rd_sticky;
		@(posedge REF_CLK) disable iff (!sync_rst_b)
		(SW_RD && !clocked_reset)
			|=> SW_RDATA[`RFA_STICKY_MSB:`RFA_STICKY_LSB] == $past(STICKY_BITS);
	endproperty
	a_rd_sticky: assert property (p_rd_sticky) else $error("Sticky bits read wrong.");

	property p_clocked_clear;
		@(posedge REF_CLK) disable iff (!sync_rst_b)
		clocked_reset |=> RW_FIELD == `RFA_RW_RST && RWH_FIELD == `RFA_RWH_RST
			&& HARDWARE_STATUS_FIELD == `RFA_STAT_RST && STICKY_BITS == STICKY_RST && !SW_RVALID;
	endproperty
	a_clocked_clear: assert property (p_clocked_clear) else $error("Clocked reset missed.");

	// No disable here, since the reset itself is what this one watches.
	property p_async_clear;
		@(posedge REF_CLK)
		!INT_RST_B |-> RW_FIELD == `RFA_RW_RST && WO_FIELD == `RFA_WO_RST
			&& STICKY_BITS == STICKY_RST && FETCH_BIT == `RFA_FETCH_RST && !SW_RVALID;
	endproperty
	a_async_clear: assert property (p_async_clear) else $error("State not held in reset.");

endmodule : rfa_regs

`default_nettype wire

// ### rfa_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rfa_cfg.svh"
module rfa_regs_tb_top;
	import rfa_pkg::*;
	logic ref_clk = 1'h0;
	logic rst_b = 1'h0;
	logic [4:0] trig = 5'h00;
	logic sw_wr = 1'h0, sw_rd = 1'h0, sw_fetch = 1'h0, sw_rvalid;
	logic rwh_ld = 1'h0, st_ld = 1'h0, sk_ld = 1'h0, sk_val = 1'h0;
	rfa_word_type sw_wdata = 32'h0, sw_rdata, rd_word;
	rfa_field_type rwh_val = 4'h0, st_val = 4'h0, rw_f, rwh_f, wo_f, st_f;
	logic [1:0] sticky;
	logic fetch_bit, int_rst_b, clocked_reset;
	int n_fail = 0;
	int samples_checked = 0;

	rfa_regs uut (.REF_CLK(ref_clk), .RST_B(rst_b),
		.EXTERNAL_REQUEST_INPUT_A(trig[0]), .EXTERNAL_REQUEST_INPUT_B(trig[1]),
		.WATCHDOG_TRIGGER(trig[2]), .PARITY_TRIGGER(trig[3]), .SW_RESET_TRIGGER(trig[4]),
		.SW_WR(sw_wr), .SW_WDATA(sw_wdata), .SW_RD(sw_rd), .SW_FETCH(sw_fetch),
		.SW_RDATA(sw_rdata), .SW_RVALID(sw_rvalid), .HW_RWH_LOAD(rwh_ld),
		.HW_RWH_VALUE(rwh_val), .HW_STATUS_LOAD(st_ld), .HW_STATUS_VALUE(st_val),
		.HW_STICKY_LOAD(sk_ld), .HW_STICKY_VALUE(sk_val), .RW_FIELD(rw_f), .RWH_FIELD(rwh_f),
		.WO_FIELD(wo_f), .HARDWARE_STATUS_FIELD(st_f), .STICKY_BITS(sticky),
		.FETCH_BIT(fetch_bit), .INT_RST_B(int_rst_b), .CLOCKED_RESET(clocked_reset));

	////////////////////////////////////////////////////////////////////////////////
	task report_and_stop;
		$display("checks=%0d mismatches=%0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop

	task chk(input rfa_word_type got, input rfa_word_type exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Field outputs are packed as rw, rwh, wo, status, sticky, fetch bit.
	function automatic rfa_word_type flds();
		return 32'({rw_f, rwh_f, wo_f, st_f, sticky, fetch_bit});
	endfunction : flds

	task wr(input rfa_word_type d);
		@(posedge ref_clk);
		sw_wr <= 1'h1;
		sw_wdata <= d;
		@(posedge ref_clk);
		sw_wr <= 1'h0;
		#1;
	endtask : wr

	task rd(input logic f);
		@(posedge ref_clk);
		sw_rd <= 1'h1;
		sw_fetch <= f;
		@(posedge ref_clk);
		sw_rd <= 1'h0;
		sw_fetch <= 1'h0;
		#1;
		chk(32'(sw_rvalid), 32'h1);
		rd_word = sw_rdata;
	endtask : rd

	////////////////////////////////////////////////////////////////////////////////
	task t_field_types;
		wr({9'h1FF, 1'h1, 2'h0, 4'hC, 4'h9, 4'h3, 4'h6, 4'h5});
		chk(flds(), 32'({4'h5, 4'h6, 4'h9, 4'h0, 2'h0, 1'h1}));
		rd(1'h0);
		chk(rd_word, {9'h000, 1'h0, 6'h00, 4'h0, `RFA_RO_DEFAULT, 4'h6, 4'h5});
		rd(1'h1);
		chk(rd_word, {9'h000, 1'h1, 6'h00, 4'h0, `RFA_RO_DEFAULT, 4'h6, 4'h5});
	endtask : t_field_types

	// Software and hardware hit the same fields in one cycle.
	task t_hw_priority;
		@(posedge ref_clk);
		sw_wr <= 1'h1;
		sw_wdata <= {9'h000, 1'h1, 2'h0, 4'h7, 4'h9, 4'h0, 4'h3, 4'h2};
		rwh_ld <= 1'h1;
		rwh_val <= 4'hE;
		st_ld <= 1'h1;
		st_val <= 4'hC;
		@(posedge ref_clk);
		sw_wr <= 1'h0;
		rwh_ld <= 1'h0;
		st_ld <= 1'h0;
		#1;
		chk(flds(), 32'({4'h2, 4'hE, 4'h9, 4'hC, 2'h0, 1'h1}));
		rd(1'h0);
		chk(rd_word, {9'h000, 1'h0, 2'h0, 4'hC, 4'h0, `RFA_RO_DEFAULT, 4'hE, 4'h2});
	endtask : t_hw_priority

	task t_sticky;
		wr({9'h000, 1'h0, 2'h3, 20'h00000});
		chk(32'(sticky), 32'h3);
		wr(32'h0);
		chk(32'(sticky), 32'h3);
		@(posedge ref_clk);
		sk_ld <= 1'h1;
		@(posedge ref_clk);
		sk_ld <= 1'h0;
		#1;
		chk(32'(sticky), 32'h1);
		@(posedge ref_clk);
		sk_ld <= 1'h1;
		sk_val <= 1'h1;
		@(posedge ref_clk);
		sk_ld <= 1'h0;
		sk_val <= 1'h0;
		#1;
		chk(32'(sticky), 32'h3);
	endtask : t_sticky

	// Reset is pulled with no further clock edge before the check.
	task t_async_reset;
		@(posedge ref_clk);
		rst_b <= 1'h0;
		#1;
		chk(flds(), 32'h0);
		chk(32'(int_rst_b), 32'h0);
		@(posedge ref_clk);
		rst_b <= 1'h1;
		repeat (2) @(posedge ref_clk);
		#1;
		chk(32'(int_rst_b), 32'h0);
		@(posedge ref_clk);
		#1;
		chk(32'(int_rst_b), 32'h1);
	endtask : t_async_reset

	// The pin requests pass a filter, so the waits allow a dozen cycles.
	task t_clocked_reset(input int i);
		int k;
		wr(32'h00000007);
		@(posedge ref_clk);
		trig <= 5'h01 << i;
		for (k = 0; k < 12 && clocked_reset !== 1'h1; k++) begin
			@(posedge ref_clk);
			#1;
		end
		chk(32'(clocked_reset), 32'h1);
		@(posedge ref_clk);
		#1;
		chk(32'(rw_f), 32'h0);
		@(posedge ref_clk);
		trig <= 5'h00;
		for (k = 0; k < 12 && (clocked_reset !== 1'h0 || int_rst_b !== 1'h1); k++) begin
			@(posedge ref_clk);
			#1;
		end
		chk(32'({clocked_reset, int_rst_b}), 32'h1);
	endtask : t_clocked_reset

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #50 ref_clk = ~ref_clk;
	end

	initial begin
		#200000;
		n_fail++;
		report_and_stop;
	end

	initial begin
		repeat (10) @(posedge ref_clk);
		rst_b <= 1'h1;
		repeat (4) @(posedge ref_clk);
		#1;
		chk(32'({int_rst_b, clocked_reset, sw_rvalid}), 32'h4);
		chk(flds(), 32'h0);
		t_field_types();
		t_hw_priority();
		t_sticky();
		t_async_reset();
		for (int i = 0; i < 5; i++) begin
			t_clocked_reset(i);
		end
		report_and_stop;
	end
endmodule : rfa_regs_tb_top
`default_nettype wire
